// ### aim_limit_monitor.sv
// parameter record, threshold events and interrupt record of a two channel input module
`timescale 1ns/1ns
module aim_limit_monitor (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // parameter record port
  input wire logic PARAM_WE,
  input wire logic [4:0] PARAM_ADDR,
  input wire logic [7:0] PARAM_WDATA,
  output logic [7:0] PARAM_RDATA,
  // samples from the converter
  input wire logic SAMPLE_VALID,
  input wire logic SAMPLE_CH,
  input wire logic signed [16:0] SAMPLE_RAW,
  // scaled measured values
  output logic MEAS_VALID,
  output logic MEAS_CH,
  output logic [15:0] MEAS_VALUE,
  // front end control
  output logic [1:0] HUM_REJECT_CH0,
  output logic [1:0] HUM_REJECT_CH1,
  output logic [1:0] CH_ACTIVE,
  // process interrupt and record
  output logic PROC_IRQ,
  input wire logic PROC_ACK,
  input wire logic [2:0] REC_ADDR,
  output logic [7:0] REC_RDATA,
  // diagnostics
  input wire logic DIAG_BUF_OVERFLOW,
  input wire logic COMM_ERROR,
  output logic DIAG_IRQ,
  output logic [5:0] DIAG_CAUSE,
  input wire logic DIAG_ACK,
  output logic PARAM_ERROR,
  output logic [31:0] US_TICKER
);
  typedef struct packed {
    // parameter record
    logic [7:0] diag_ctrl;
    logic [7:0] watch_en;
    logic [7:0] hum;
    logic [1:0][7:0] range_code;
    logic [1:0][15:0] high_thr;
    logic [1:0][15:0] low_thr;
    // process interrupt record
    logic [7:0] high_hits;
    logic [7:0] low_hits;
    logic [15:0] stamp;
    logic proc_pending;
    // sticky diagnostic causes
    logic [5:0] cause;
    // last scaled value
    logic meas_valid;
    logic meas_ch;
    logic [15:0] meas_value;
  } aim_state_s;

  aim_state_s st_reg;
  aim_state_s st_next;

  logic [31:0] us_count;
  // per channel results
  logic [1:0] ch_active;
  logic [1:0] ch_perr;
  logic [1:0] ch_over;
  logic [1:0] ch_under;
  logic [1:0] ch_high;
  logic [1:0] ch_low;
  logic [1:0][15:0] ch_value;
  logic [1:0][1:0] ch_hum;
  logic diag_perr;
  // parameter address decode
  logic sel;
  logic [2:0] ofs;
  logic in_ch;
  // event and cause assembly
  logic ch_hit;
  logic [7:0] new_high;
  logic [7:0] new_low;
  logic [5:0] cause_set;
  logic [7:0] rd;

  aim_us_ticker u_ticker (
    .clock(CLOCK),
    .rst_n(RSTN),
    .us_count(us_count)
  );

  assign ch_hum[0] = st_reg.hum[1:0];
  assign ch_hum[1] = st_reg.hum[3:2];

  // per channel checks
  // both checkers see the same raw sample, only the addressed one is used
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      aim_chan_check u_check (
        .range_code(st_reg.range_code[gi]),
        .high_thr(st_reg.high_thr[gi]),
        .low_thr(st_reg.low_thr[gi]),
        .hum_code(ch_hum[gi]),
        .raw(SAMPLE_RAW),
        .active(ch_active[gi]),
        .param_err(ch_perr[gi]),
        .value(ch_value[gi]),
        .range_over(ch_over[gi]),
        .range_under(ch_under[gi]),
        .high_hit(ch_high[gi]),
        .low_hit(ch_low[gi])
      );
    end
  endgenerate

  // parameter address split into channel block and offset
  // both blocks share one offset map so a single case serves either channel
  always_comb begin
    sel = 1'b0;
    ofs = 3'h0;
    in_ch = 1'b0;
    if (PARAM_ADDR >= aim_pkg::PAR_CH1_BASE && PARAM_ADDR <= aim_pkg::PAR_LAST) begin
      sel = 1'b1;
      ofs = 3'(PARAM_ADDR - aim_pkg::PAR_CH1_BASE);
      in_ch = 1'b1;
    end else if (PARAM_ADDR >= aim_pkg::PAR_CH0_BASE && PARAM_ADDR < aim_pkg::PAR_CH1_BASE) begin
      ofs = 3'(PARAM_ADDR - aim_pkg::PAR_CH0_BASE);
      in_ch = 1'b1;
    end
  end

  // only the enable and disable codes are legal
  // any other code also keeps the diagnostic interrupt off
  assign diag_perr = (st_reg.diag_ctrl != aim_pkg::DIAG_ENABLE) &&
                     (st_reg.diag_ctrl != aim_pkg::DIAG_DISABLE);

  always_comb begin
    st_next = st_reg;
    // parameter writes, reserved bits and bytes dropped
    if (PARAM_WE) begin
      if (PARAM_ADDR == aim_pkg::PAR_DIAG) begin
        // stored whole so a bad code is seen
        st_next.diag_ctrl = PARAM_WDATA;
      end else if (PARAM_ADDR == aim_pkg::PAR_WATCH_EN) begin
        st_next.watch_en = PARAM_WDATA & aim_pkg::WATCH_MASK;
      end else if (PARAM_ADDR == aim_pkg::PAR_HUM_REJECT) begin
        st_next.hum = PARAM_WDATA & aim_pkg::HUM_MASK;
      end else if (in_ch) begin
        case (ofs)
          aim_pkg::CH_RANGE_OFS: st_next.range_code[sel] = PARAM_WDATA;
          aim_pkg::CH_HIGH_MSB_OFS: st_next.high_thr[sel][15:8] = PARAM_WDATA;
          aim_pkg::CH_HIGH_LSB_OFS: st_next.high_thr[sel][7:0] = PARAM_WDATA;
          aim_pkg::CH_LOW_MSB_OFS: st_next.low_thr[sel][15:8] = PARAM_WDATA;
          aim_pkg::CH_LOW_LSB_OFS: st_next.low_thr[sel][7:0] = PARAM_WDATA;
          // reserved byte inside a channel block
          default: st_next.range_code[sel] = st_reg.range_code[sel];
        endcase
      end
    end

    // scaled value output, deactivated channels give no value
    // the value holds between samples, only the valid strobe pulses
    st_next.meas_valid = SAMPLE_VALID && ch_active[SAMPLE_CH];
    st_next.meas_ch = SAMPLE_CH;
    if (SAMPLE_VALID && ch_active[SAMPLE_CH]) begin
      st_next.meas_value = ch_value[SAMPLE_CH];
    end

    // threshold event of the sampled channel when watched
    new_high = 8'h00;
    new_low = 8'h00;
    new_high[SAMPLE_CH] = ch_high[SAMPLE_CH];
    new_low[SAMPLE_CH] = ch_low[SAMPLE_CH];
    // watch bit gates the event only
    ch_hit = SAMPLE_VALID && st_reg.watch_en[SAMPLE_CH] && (ch_high[SAMPLE_CH] || ch_low[SAMPLE_CH]);

    cause_set = '0;
    cause_set[aim_pkg::CAUSE_PARAM] = diag_perr || (|ch_perr);
    cause_set[aim_pkg::CAUSE_OVER] = SAMPLE_VALID && ch_over[SAMPLE_CH];
    cause_set[aim_pkg::CAUSE_UNDER] = SAMPLE_VALID && ch_under[SAMPLE_CH];
    cause_set[aim_pkg::CAUSE_BUF] = DIAG_BUF_OVERFLOW;
    cause_set[aim_pkg::CAUSE_COMM] = COMM_ERROR;
    // a record still pending means the new event is lost
    cause_set[aim_pkg::CAUSE_LOST] = ch_hit && st_reg.proc_pending && !PROC_ACK;

    // acknowledge clears, a same cycle event wins
    if (PROC_ACK) begin
      st_next.proc_pending = 1'b0;
      st_next.high_hits = 8'h00;
      st_next.low_hits = 8'h00;
    end
    // new record only when none is pending or this edge frees it
    if (ch_hit && (!st_reg.proc_pending || PROC_ACK)) begin
      st_next.proc_pending = 1'b1;
      st_next.high_hits = new_high & aim_pkg::FLAG_MASK;
      st_next.low_hits = new_low & aim_pkg::FLAG_MASK;
      // low half of the microsecond counter
      // the value before this edge, the instant the sample was taken
      st_next.stamp = us_count[15:0];
    end

    // clear first so a cause raised in the same cycle stays
    if (DIAG_ACK) begin
      st_next.cause = '0;
    end
    st_next.cause = st_next.cause | cause_set;
  end

  // parameter bytes come up at their defaults, everything else at zero
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      st_reg <= '0;
      st_reg.diag_ctrl <= aim_pkg::DIAG_RESET;
      st_reg.watch_en <= aim_pkg::WATCH_RESET;
      st_reg.hum <= aim_pkg::HUM_RESET;
      st_reg.range_code[0] <= aim_pkg::RANGE_RESET;
      st_reg.range_code[1] <= aim_pkg::RANGE_RESET;
      st_reg.high_thr[0] <= aim_pkg::HIGH_OFF;
      st_reg.high_thr[1] <= aim_pkg::HIGH_OFF;
      st_reg.low_thr[0] <= aim_pkg::LOW_OFF;
      st_reg.low_thr[1] <= aim_pkg::LOW_OFF;
    end else begin
      st_reg <= st_next;
    end
  end

  // parameter read back, reserved bytes read zero
  // masked bits were never stored, so they read zero
  always_comb begin
    rd = 8'h00;
    if (PARAM_ADDR == aim_pkg::PAR_DIAG) begin
      rd = st_reg.diag_ctrl;
    end else if (PARAM_ADDR == aim_pkg::PAR_WATCH_EN) begin
      rd = st_reg.watch_en;
    end else if (PARAM_ADDR == aim_pkg::PAR_HUM_REJECT) begin
      rd = st_reg.hum;
    end else if (in_ch) begin
      case (ofs)
        aim_pkg::CH_RANGE_OFS: rd = st_reg.range_code[sel];
        aim_pkg::CH_HIGH_MSB_OFS: rd = st_reg.high_thr[sel][15:8];
        aim_pkg::CH_HIGH_LSB_OFS: rd = st_reg.high_thr[sel][7:0];
        aim_pkg::CH_LOW_MSB_OFS: rd = st_reg.low_thr[sel][15:8];
        aim_pkg::CH_LOW_LSB_OFS: rd = st_reg.low_thr[sel][7:0];
        default: rd = 8'h00;
      endcase
    end
  end
  assign PARAM_RDATA = rd;

  // interrupt record read
  // flags and stamp bytes
  always_comb begin
    case (REC_ADDR)
      aim_pkg::REC_HIGH_HITS: REC_RDATA = st_reg.high_hits;
      aim_pkg::REC_LOW_HITS: REC_RDATA = st_reg.low_hits;
      aim_pkg::REC_STAMP_LSB: REC_RDATA = st_reg.stamp[7:0];
      aim_pkg::REC_STAMP_MSB: REC_RDATA = st_reg.stamp[15:8];
      default: REC_RDATA = 8'h00;
    endcase
  end

  assign PROC_IRQ = st_reg.proc_pending;
  // enable gate on the diagnostic interrupt
  assign DIAG_IRQ = (st_reg.diag_ctrl == aim_pkg::DIAG_ENABLE) && (|st_reg.cause);

  // sticky causes and the live error level
  assign DIAG_CAUSE = st_reg.cause;
  assign PARAM_ERROR = diag_perr || (|ch_perr);

  // measured values and front end control
  assign MEAS_VALID = st_reg.meas_valid;
  assign MEAS_CH = st_reg.meas_ch;
  assign MEAS_VALUE = st_reg.meas_value;
  assign HUM_REJECT_CH0 = ch_hum[0];
  assign HUM_REJECT_CH1 = ch_hum[1];
  assign CH_ACTIVE = ch_active;

  assign US_TICKER = us_count;
endmodule // aim_limit_monitor

// ### aim_pkg.sv
// constants shared by the analog input limit monitor
package aim_pkg;
  // parameter record byte offsets
  localparam logic [4:0] PAR_DIAG = 5'h00;
  localparam logic [4:0] PAR_WATCH_EN = 5'h02;
  localparam logic [4:0] PAR_HUM_REJECT = 5'h03;
  localparam logic [4:0] PAR_CH0_BASE = 5'h04;
  localparam logic [4:0] PAR_CH1_BASE = 5'h0a;
  // offsets inside one channel block
  localparam logic [2:0] CH_RANGE_OFS = 3'h0;
  localparam logic [2:0] CH_HIGH_MSB_OFS = 3'h2;
  localparam logic [2:0] CH_HIGH_LSB_OFS = 3'h3;
  localparam logic [2:0] CH_LOW_MSB_OFS = 3'h4;
  localparam logic [2:0] CH_LOW_LSB_OFS = 3'h5;
  localparam logic [4:0] PAR_LAST = 5'h0f;
  // interrupt record byte offsets
  localparam logic [2:0] REC_HIGH_HITS = 3'h2;
  localparam logic [2:0] REC_LOW_HITS = 3'h3;
  localparam logic [2:0] REC_STAMP_LSB = 3'h4;
  localparam logic [2:0] REC_STAMP_MSB = 3'h5;
  // field layouts
  localparam int WATCH_CH0_BIT = 0;
  localparam int WATCH_CH1_BIT = 1;
  localparam logic [7:0] WATCH_MASK = 8'h03;
  localparam logic [7:0] HUM_MASK = 8'h0f;
  localparam logic [7:0] FLAG_MASK = 8'h03;
  // diagnostic control codes
  localparam logic [7:0] DIAG_ENABLE = 8'h00;
  localparam logic [7:0] DIAG_DISABLE = 8'h40;
  // mains rejection codes
  localparam logic [1:0] HUM_OFF = 2'h0;
  localparam logic [1:0] HUM_60HZ = 2'h1;
  localparam logic [1:0] HUM_50HZ = 2'h2;
  // range codes
  localparam logic [7:0] RANGE_DEC = 8'h10;
  localparam logic [7:0] RANGE_BIN = 8'h20;
  localparam logic [7:0] RANGE_OFF = 8'hff;
  // scaling limits, two's complement
  localparam logic signed [15:0] DEC_NOMINAL = 16'sh6c00;
  localparam logic signed [15:0] DEC_OVER = 16'sh7eff;
  localparam logic signed [15:0] DEC_UNDER = 16'shed00;
  localparam logic signed [15:0] BIN_NOMINAL = 16'sh4000;
  localparam logic signed [15:0] BIN_OVER = 16'sh5000;
  localparam logic signed [15:0] BIN_UNDER = 16'shf333;
  localparam logic signed [15:0] NOMINAL_ZERO = 16'sh0000;
  // threshold disable codes
  localparam logic [15:0] HIGH_OFF = 16'h7fff;
  localparam logic [15:0] LOW_OFF = 16'h8000;
  // reset values
  localparam logic [7:0] DIAG_RESET = 8'h00;
  localparam logic [7:0] WATCH_RESET = 8'h00;
  localparam logic [7:0] HUM_RESET = 8'h00;
  localparam logic [7:0] RANGE_RESET = 8'h10;
  // microsecond tick
  localparam int CLOCK_HZ = 20000000;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = CLOCK_HZ / 1000000 * TICK_US;
  // diagnostic cause bits
  localparam int CAUSE_PARAM = 0;
  localparam int CAUSE_OVER = 1;
  localparam int CAUSE_UNDER = 2;
  localparam int CAUSE_BUF = 3;
  localparam int CAUSE_COMM = 4;
  localparam int CAUSE_LOST = 5;
  localparam int CAUSE_W = 6;
endpackage

// ### aim_us_ticker.sv
// free running 32-bit microsecond counter
`timescale 1ns/1ns
module aim_us_ticker (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // count
  output logic [31:0] us_count
);
  typedef struct packed {
    logic [4:0] pre;
    logic [31:0] us;
  } aim_tick_s;

  aim_tick_s st_reg;
  aim_tick_s st_next;

  always_comb begin
    st_next = st_reg;
    if (st_reg.pre == 5'(aim_pkg::TICK_CYCLES - 1)) begin
      st_next.pre = 5'h00;
      st_next.us = st_reg.us + 32'h00000001;
    end else begin
      st_next.pre = st_reg.pre + 5'h01;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign us_count = st_reg.us;
endmodule // aim_us_ticker

// ### aim_chan_check.sv
// per channel scaling, parameter check and threshold compare
`timescale 1ns/1ns
module aim_chan_check (
  // channel parameters
  input wire logic [7:0] range_code,
  input wire logic [15:0] high_thr,
  input wire logic [15:0] low_thr,
  input wire logic [1:0] hum_code,
  // raw sample, 10 V = 32768
  input wire logic signed [16:0] raw,
  // results
  output logic active,
  output logic param_err,
  output logic signed [15:0] value,
  output logic range_over,
  output logic range_under,
  output logic high_hit,
  output logic low_hit
);
  logic signed [21:0] dec_wide;
  logic signed [21:0] bin_wide;
  logic signed [21:0] scaled;
  logic signed [15:0] nom;
  logic signed [15:0] over_lim;
  logic signed [15:0] under_lim;
  logic high_on;
  logic low_on;
  logic high_bad;
  logic low_bad;

  always_comb begin
    // decimal scale is raw*27/32, binary scale is raw/2
    dec_wide = (22'(raw) * 22'sd27) >>> 5;
    bin_wide = 22'(raw) >>> 1;
    nom = aim_pkg::DEC_NOMINAL;
    over_lim = aim_pkg::DEC_OVER;
    under_lim = aim_pkg::DEC_UNDER;
    scaled = dec_wide;
    if (range_code == aim_pkg::RANGE_BIN) begin
      nom = aim_pkg::BIN_NOMINAL;
      over_lim = aim_pkg::BIN_OVER;
      under_lim = aim_pkg::BIN_UNDER;
      scaled = bin_wide;
    end
    active = (range_code == aim_pkg::RANGE_DEC) || (range_code == aim_pkg::RANGE_BIN);
    // clamp to over and under range
    range_over = active && (scaled >= 22'(over_lim));
    range_under = active && (scaled <= 22'(under_lim));
    if (range_over) begin
      value = over_lim;
    end else if (range_under) begin
      value = under_lim;
    end else begin
      value = scaled[15:0];
    end
    high_on = (high_thr != aim_pkg::HIGH_OFF);
    low_on = (low_thr != aim_pkg::LOW_OFF);
    high_bad = high_on && (($signed(high_thr) < aim_pkg::NOMINAL_ZERO) || ($signed(high_thr) > nom));
    low_bad = low_on && (($signed(low_thr) < aim_pkg::NOMINAL_ZERO) || ($signed(low_thr) > nom));
    param_err = (!active && range_code != aim_pkg::RANGE_OFF) ||
                (active && (high_bad || low_bad || hum_code == 2'h3));
    high_hit = active && high_on && !high_bad && (value > $signed(high_thr));
    low_hit = active && low_on && !low_bad && (value < $signed(low_thr));
  end
endmodule // aim_chan_check

// ### aim_limit_monitor_sva.sv
// port checker for the analog input limit monitor
`timescale 1ns/1ns
module aim_limit_monitor_sva (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // parameter port
  input wire logic PARAM_WE,
  input wire logic [4:0] PARAM_ADDR,
  input wire logic [7:0] PARAM_RDATA,
  // samples and measurements
  input wire logic SAMPLE_VALID,
  input wire logic SAMPLE_CH,
  input wire logic MEAS_VALID,
  input wire logic MEAS_CH,
  input wire logic [1:0] HUM_REJECT_CH0,
  input wire logic [1:0] CH_ACTIVE,
  // interrupts and record
  input wire logic PROC_IRQ,
  input wire logic PROC_ACK,
  input wire logic [2:0] REC_ADDR,
  input wire logic [7:0] REC_RDATA,
  input wire logic COMM_ERROR,
  input wire logic DIAG_IRQ,
  input wire logic [5:0] DIAG_CAUSE,
  input wire logic DIAG_ACK,
  input wire logic PARAM_ERROR,
  input wire logic [31:0] US_TICKER
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  meas_follow_a: assert property (
    SAMPLE_VALID && CH_ACTIVE[SAMPLE_CH] |=> MEAS_VALID && MEAS_CH == $past(SAMPLE_CH))
    else $error("measurement missing after sample");
  meas_quiet_a: assert property (!(SAMPLE_VALID && CH_ACTIVE[SAMPLE_CH]) |=> !MEAS_VALID)
    else $error("measurement without active sample");
  diag_gate_a: assert property (
    PARAM_ADDR == 5'h00 |-> DIAG_IRQ == (PARAM_RDATA == 8'h00 && DIAG_CAUSE != 6'h00))
    else $error("diagnostic interrupt gating wrong");
  watch_mask_a: assert property (PARAM_ADDR == 5'h02 |-> PARAM_RDATA[7:2] == 6'h00)
    else $error("reserved watch bits set");
  hum_out_a: assert property (
    PARAM_ADDR == 5'h03 && !PARAM_WE && $past(!PARAM_WE) && $past(!PARAM_WE, 2)
    |-> PARAM_RDATA[7:4] == 4'h0 && HUM_REJECT_CH0 == PARAM_RDATA[1:0])
    else $error("mains code output mismatch");
  flag_mask_a: assert property (REC_ADDR inside {3'h2, 3'h3} |-> REC_RDATA[7:2] == 6'h00)
    else $error("reserved flag bits set");
  irq_hold_a: assert property (PROC_IRQ && !PROC_ACK |=> PROC_IRQ)
    else $error("process interrupt dropped");
  ack_clear_a: assert property (PROC_ACK && !SAMPLE_VALID |=> !PROC_IRQ)
    else $error("process interrupt not cleared");
  ticker_step_a: assert property (
    $changed(US_TICKER) |-> US_TICKER == $past(US_TICKER) + 32'h1 ##20 $changed(US_TICKER))
    else $error("microsecond ticker step wrong");
  stamp_low_a: assert property ($rose(PROC_IRQ) && REC_ADDR == 3'h4 |->
    REC_RDATA == 8'($past(US_TICKER)))
    else $error("time stamp low byte wrong");
  cause_keep_a: assert property (!DIAG_ACK |=>
    (DIAG_CAUSE & $past(DIAG_CAUSE)) == $past(DIAG_CAUSE))
    else $error("diagnostic cause lost");
  cause_set_a: assert property (
    (PARAM_ERROR |=> DIAG_CAUSE[0]) and (COMM_ERROR |=> DIAG_CAUSE[4]))
    else $error("diagnostic cause not set");
  cover property (PROC_IRQ && PROC_ACK);
  cover property ($rose(DIAG_IRQ));
  cover property (MEAS_VALID && MEAS_CH);
endmodule // aim_limit_monitor_sva

bind aim_limit_monitor aim_limit_monitor_sva i_sva (.*);

// ### aim_host_model.sv
// backplane master model: parameter writes, reads and acknowledges
`timescale 1ns/1ns
module aim_host_model (
  // clock
  input wire logic CLOCK,
  // parameter port
  output logic PARAM_WE,
  output logic [4:0] PARAM_ADDR,
  output logic [7:0] PARAM_WDATA,
  input wire logic [7:0] PARAM_RDATA,
  // acknowledges
  output logic PROC_ACK,
  output logic DIAG_ACK
);
  initial begin
    PARAM_WE = 1'b0;
    PARAM_ADDR = 5'h00;
    PARAM_WDATA = 8'h00;
    PROC_ACK = 1'b0;
    DIAG_ACK = 1'b0;
  end
  // one byte per strobe; data scrambled after so a stale value never looks valid
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge CLOCK);
    PARAM_WE = 1'b1;
    PARAM_ADDR = a;
    PARAM_WDATA = d;
    @(negedge CLOCK);
    PARAM_WE = 1'b0;
    PARAM_WDATA = ~d;
  endtask
  // thresholds go higher byte first, at the lower offset
  task automatic wr16(input logic [4:0] a, input logic [15:0] d);
    wr(a, d[15:8]);
    wr(a + 5'h01, d[7:0]);
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge CLOCK);
    PARAM_ADDR = a;
    @(posedge CLOCK);
    d = PARAM_RDATA;
  endtask
  task automatic ack(input logic diag);
    @(negedge CLOCK);
    PROC_ACK = ~diag;
    DIAG_ACK = diag;
    @(negedge CLOCK);
    PROC_ACK = 1'b0;
    DIAG_ACK = 1'b0;
  endtask
endmodule // aim_host_model

// ### testbench.sv
// self-checking testbench for the limit monitor
`timescale 1ns/1ns
module testbench;
  logic CLOCK = 1'b0;
  logic RSTN = 1'b0;
  logic SAMPLE_VALID = 1'b0;
  logic SAMPLE_CH = 1'b0;
  logic signed [16:0] SAMPLE_RAW = 17'sh00000;
  logic [2:0] REC_ADDR = 3'h4;
  logic DIAG_BUF_OVERFLOW = 1'b0;
  logic COMM_ERROR = 1'b0;
  logic PARAM_WE, MEAS_VALID, MEAS_CH, PROC_IRQ, PROC_ACK, DIAG_IRQ, DIAG_ACK, PARAM_ERROR;
  logic [4:0] PARAM_ADDR;
  logic [7:0] PARAM_WDATA, PARAM_RDATA, REC_RDATA, d;
  logic [15:0] MEAS_VALUE;
  logic [1:0] HUM_REJECT_CH0, HUM_REJECT_CH1, CH_ACTIVE;
  logic [5:0] DIAG_CAUSE;
  logic [31:0] US_TICKER, stamp;
  logic [31:0] lfsr = 32'hfb28;
  logic signed [16:0] r;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  always #25 CLOCK = ~CLOCK;
  aim_limit_monitor i_dut (.*);
  aim_host_model i_host (.*);
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // generous ceiling, the sequence needs a few hundred cycles
  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      stop_test();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] par_reset(input int a);
    case (a)
      4, 10: return 8'h10;
      6, 12: return 8'h7f;
      7, 13: return 8'hff;
      8, 14: return 8'h80;
      default: return 8'h00;
    endcase
  endfunction
  // raw is kept a multiple of 32 so the scaling division is exact
  function automatic logic [15:0] scale(input logic bin, input logic signed [16:0] x);
    int v;
    v = bin ? x / 2 : x * 27 / 32;
    if (v > (bin ? 20480 : 32511))
      v = bin ? 20480 : 32511;
    if (v < (bin ? -3277 : -4864))
      v = bin ? -3277 : -4864;
    return v[15:0];
  endfunction
  task automatic smp(input logic ch, input logic signed [16:0] x);
    @(negedge CLOCK);
    SAMPLE_VALID = 1'b1;
    SAMPLE_CH = ch;
    SAMPLE_RAW = x;
    stamp = US_TICKER;
    @(negedge CLOCK);
    SAMPLE_VALID = 1'b0;
    SAMPLE_RAW = ~x;
  endtask
  task automatic rec(input logic [7:0] hi, input logic [7:0] lo);
    chk("proc_irq", 1'b1, PROC_IRQ);
    for (int a = 2; a < 6; a++) begin
      @(negedge CLOCK);
      REC_ADDR = a[2:0];
      #1 chk("record", a == 2 ? hi : a == 3 ? lo : a == 4 ? stamp[7:0] : stamp[15:8], REC_RDATA);
    end
    @(negedge CLOCK);
    REC_ADDR = 3'h4;
    i_host.ack(1'b0);
    chk("irq_clear", 1'b0, PROC_IRQ);
  endtask
  initial begin
    repeat (5) @(posedge CLOCK);
    @(negedge CLOCK);
    RSTN = 1'b1;
    chk("ticker", 32'h0, US_TICKER);
    for (int a = 0; a < 16; a++) begin
      i_host.rd(a[4:0], d);
      chk("par_reset", par_reset(a), d);
    end
    i_host.wr(5'h01, 8'hff);
    i_host.wr(5'h02, 8'hff);
    i_host.rd(5'h01, d);
    chk("res_byte", 8'h00, d);
    i_host.rd(5'h02, d);
    chk("watch", 8'h03, d);
    for (int c = 0; c < 3; c++) begin
      i_host.wr(5'h03, {4'hf, 2'(2 - c), c[1:0]});
      repeat (3) @(negedge CLOCK);
      chk("hum0", c, HUM_REJECT_CH0);
      chk("hum1", 2 - c, HUM_REJECT_CH1);
      i_host.rd(5'h03, d);
      chk("hum_rd", {4'h0, 2'(2 - c), c[1:0]}, d);
    end
    i_host.wr(5'h03, 8'h03);
    chk("hum_bad", 1'b1, PARAM_ERROR);
    i_host.wr(5'h03, 8'h02);
    chk("hum_ok", 1'b0, PARAM_ERROR);
    i_host.wr(5'h0a, 8'hff);
    smp(1'b1, 17'sh08000);
    chk("active", 2'b01, CH_ACTIVE);
    chk("meas_off", 1'b0, MEAS_VALID);
    i_host.wr(5'h0a, 8'h33);
    chk("bad_range", 1'b1, PARAM_ERROR);
    i_host.wr(5'h0a, 8'h20);
    for (int i = 0; i < 40; i++) begin
      lfsr = step(lfsr);
      r = i < 2 ? 17'sh08000 : {lfsr[16:5], 5'h00};
      smp(i < 2 ? i[0] : lfsr[20], r);
      chk("meas_value", scale(SAMPLE_CH, r), MEAS_VALUE);
      chk("meas_valid", 1'b1, MEAS_VALID);
    end
    i_host.wr16(5'h06, 16'h3600);
    smp(1'b0, 17'sh04200);
    rec(8'h01, 8'h00);
    i_host.wr16(5'h0e, 16'h2000);
    smp(1'b1, 17'sh02000);
    rec(8'h00, 8'h02);
    i_host.wr16(5'h06, 16'h7fff);
    smp(1'b0, 17'sh08000);
    chk("high_off", 1'b0, PROC_IRQ);
    i_host.wr16(5'h06, 16'h6d00);
    chk("thr_range", 1'b1, PARAM_ERROR);
    smp(1'b0, 17'sh0ffe0);
    chk("thr_bad_cmp", 1'b0, PROC_IRQ);
    chk("over_cause", 1'b1, DIAG_CAUSE[1]);
    i_host.wr16(5'h06, 16'h3600);
    i_host.wr(5'h02, 8'h02);
    smp(1'b0, 17'sh0ffe0);
    chk("unwatched", 1'b0, PROC_IRQ);
    i_host.wr(5'h02, 8'h03);
    smp(1'b0, 17'sh0ffe0);
    smp(1'b0, 17'sh0ffe0);
    chk("lost_cause", 1'b1, DIAG_CAUSE[5]);
    i_host.ack(1'b0);
    i_host.wr(5'h00, 8'h40);
    @(negedge CLOCK);
    COMM_ERROR = 1'b1;
    DIAG_BUF_OVERFLOW = 1'b1;
    @(negedge CLOCK);
    COMM_ERROR = 1'b0;
    DIAG_BUF_OVERFLOW = 1'b0;
    chk("diag_off", 1'b0, DIAG_IRQ);
    chk("buf_cause", 1'b1, DIAG_CAUSE[3]);
    i_host.wr(5'h00, 8'h00);
    i_host.rd(5'h00, d);
    chk("diag_rd", 8'h00, d);
    chk("diag_on", 1'b1, DIAG_IRQ);
    i_host.ack(1'b1);
    chk("cause_clr", 6'h00, DIAG_CAUSE);
    stop_test();
  end
endmodule // testbench
